// >>> src/wse_wake_event.sv
// Wake event status and enable block with an AXI4-Lite register slave
`timescale 1ns/1ns
module wse_wake_event (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  battery_reset_n,
    input  wire logic                  button_input_n,
    input  wire logic                  alarm_in,
    input  wire logic [7:0]            gp_low_in,
    input  wire logic [7:0]            pin_bank_in,
    input  wire wse_pkg::wse_axi_req_t axi_req,
    output wse_pkg::wse_axi_rsp_t      axi_rsp,
    output logic                       pm_event_out_n,
    output logic                       supply_on_n
);

    wse_pkg::wse_state_t state_reg;
    wse_pkg::wse_state_t state_next;

    // Register index from a byte address
    function automatic logic [7:0] reg_index(
        input logic [wse_pkg::ADDR_W-1:0] addr
    );
        reg_index = addr[9:2];
    endfunction : reg_index

    // True when the address hits a mapped, aligned word
    function automatic logic reg_mapped(
        input logic [wse_pkg::ADDR_W-1:0] addr
    );
        logic [7:0] idx;
        idx = addr[9:2];
        reg_mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0)
                     && (idx >= wse_pkg::IDX_PM_EN_LOW)
                     && (idx <= wse_pkg::IDX_SUPPLY_CTRL);
    endfunction : reg_mapped

    // Read mux over the current state
    function automatic logic [7:0] reg_read(
        input logic [7:0]          idx,
        input wse_pkg::wse_state_t s
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            wse_pkg::IDX_PM_EN_LOW:   v = 8'h00;
            wse_pkg::IDX_PM_EN_HIGH:  v = s.pm_en & wse_pkg::PM_EN_MASK;
            wse_pkg::IDX_GE_STS_LOW:  v = s.ge_sts[7:0];
            wse_pkg::IDX_GE_STS_HIGH: v = s.ge_sts[15:8];
            wse_pkg::IDX_GE_EN_LOW:   v = s.ge_en[7:0];
            wse_pkg::IDX_GE_EN_HIGH:  v = s.ge_en[15:8];
            wse_pkg::IDX_PM_STATUS: begin
                v[wse_pkg::BIT_BUTTON] = s.button_event_flag;
                v[wse_pkg::BIT_ALARM]  = s.alarm_flag;
            end
            wse_pkg::IDX_POL_LOW:     v = s.pol[7:0];
            wse_pkg::IDX_POL_HIGH:    v = s.pol[15:8];
            wse_pkg::IDX_SUPPLY_CTRL: v = {7'h00, ~s.supply_n};
            default:                  v = 8'h00;
        endcase
        reg_read = v;
    endfunction : reg_read

    // Event and write-decode terms
    logic [15:0] eff_now;
    logic [15:0] eff_old;
    logic [15:0] ge_set;
    logic        button_press;
    logic        alarm_edge;
    logic        do_write;
    logic [7:0]  w_idx;
    logic [7:0]  w_val;
    logic [15:0] ge_clr;
    logic        button_clr;
    logic        alarm_clr;
    logic        sleep_req;
    logic        pm_level;
    logic        wake_level;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;

    // Edges are judged after inversion, so polarity flips the edge
    always_comb begin
        eff_now = state_reg.sync_b[15:0] ^ state_reg.pol
                  ^ wse_pkg::FALL_MASK;
        eff_old = state_reg.prev[15:0] ^ state_reg.pol
                  ^ wse_pkg::FALL_MASK;
        // Rising of effective level sets each general event status bit, all 16 in one vector
        ge_set = eff_now & ~eff_old;
        button_press = state_reg.prev[wse_pkg::SRC_BUTTON]
                       & ~state_reg.sync_b[wse_pkg::SRC_BUTTON];
        alarm_edge = state_reg.sync_b[wse_pkg::SRC_ALARM]
                     & ~state_reg.prev[wse_pkg::SRC_ALARM];
    end

    // Register write decode; only byte lane 0 carries data
    always_comb begin
        do_write   = state_reg.aw_held && state_reg.w_held
                     && !state_reg.rsp.bvalid;
        w_idx      = reg_index(state_reg.awaddr);
        w_val      = state_reg.wlane ? state_reg.wdata : 8'h00;
        ge_clr     = 16'h0000;
        button_clr = 1'b0;
        alarm_clr  = 1'b0;
        sleep_req  = 1'b0;
        if (do_write && reg_mapped(state_reg.awaddr)) begin
            case (w_idx)
                wse_pkg::IDX_GE_STS_LOW:  ge_clr[7:0]  = w_val;
                wse_pkg::IDX_GE_STS_HIGH: ge_clr[15:8] = w_val;
                wse_pkg::IDX_PM_STATUS: begin
                    button_clr = w_val[wse_pkg::BIT_BUTTON];
                    alarm_clr  = w_val[wse_pkg::BIT_ALARM];
                end
                wse_pkg::IDX_SUPPLY_CTRL:
                    sleep_req = w_val[wse_pkg::BIT_SLEEP];
                default: sleep_req = 1'b0;
            endcase
        end
    end

    // Event and wake levels from flags and enables; wake also takes any button press, enabled or not
    always_comb begin
        pm_level = (state_reg.button_event_flag
                    & state_reg.pm_en[wse_pkg::BIT_BUTTON])
                 | (state_reg.alarm_flag
                    & state_reg.pm_en[wse_pkg::BIT_ALARM])
                 | (|(state_reg.ge_sts & state_reg.ge_en));
        wake_level = (state_reg.alarm_flag
                      & state_reg.pm_en[wse_pkg::BIT_ALARM])
                   | (|(state_reg.ge_sts & state_reg.ge_en))
                   | button_press;
    end

    // Bus handshakes on the registered ready signals
    always_comb begin
        aw_take = axi_req.awvalid && state_reg.rsp.awready;
        w_take  = axi_req.wvalid && state_reg.rsp.wready;
        ar_take = axi_req.arvalid && state_reg.rsp.arready;
    end

    // Next state of the whole block
    always_comb begin
        state_next = state_reg;

        // Two-stage synchroniser, then one stage for edge compare
        state_next.sync_a = {alarm_in, button_input_n,
                             pin_bank_in, gp_low_in};
        state_next.sync_b = state_reg.sync_a;
        state_next.prev   = state_reg.sync_b;

        // Set wins over clear in every sticky flag
        state_next.ge_sts = (state_reg.ge_sts & ~ge_clr)
                          | ge_set;
        state_next.button_event_flag =
            (state_reg.button_event_flag & ~button_clr)
            | button_press;
        state_next.alarm_flag = (state_reg.alarm_flag & ~alarm_clr)
                              | alarm_edge;

        // Plain read-write registers
        if (do_write && reg_mapped(state_reg.awaddr)) begin
            case (w_idx)
                wse_pkg::IDX_PM_EN_HIGH:
                    state_next.pm_en = w_val & wse_pkg::PM_EN_MASK;
                wse_pkg::IDX_GE_EN_LOW:  state_next.ge_en[7:0]  = w_val;
                wse_pkg::IDX_GE_EN_HIGH: state_next.ge_en[15:8] = w_val;
                wse_pkg::IDX_POL_LOW:    state_next.pol[7:0]    = w_val;
                wse_pkg::IDX_POL_HIGH:   state_next.pol[15:8]   = w_val;
                default:                 state_next.pm_en = state_reg.pm_en;
            endcase
        end

        // Wake beats a same-cycle sleep request so no wake is dropped
        state_next.pm_event_n = ~pm_level;
        if (wake_level) begin
            state_next.supply_n = 1'b0;
        end else if (sleep_req) begin
            state_next.supply_n = 1'b1;
        end

        // Write address and data are taken in either order
        if (aw_take) begin
            state_next.aw_held = 1'b1;
            state_next.awaddr  = axi_req.awaddr;
        end
        if (w_take) begin
            state_next.w_held = 1'b1;
            state_next.wdata  = axi_req.wdata[7:0];
            state_next.wlane  = axi_req.wstrb[0];
        end
        if (do_write) begin
            state_next.aw_held    = 1'b0;
            state_next.w_held     = 1'b0;
            state_next.rsp.bvalid = 1'b1;
            state_next.rsp.bresp  = reg_mapped(state_reg.awaddr)
                                    ? wse_pkg::RESP_OKAY
                                    : wse_pkg::RESP_DECERR;
        end else if (state_reg.rsp.bvalid && axi_req.bready) begin
            state_next.rsp.bvalid = 1'b0;
        end
        state_next.rsp.awready = !state_next.aw_held
                                 && !state_next.rsp.bvalid;
        state_next.rsp.wready  = !state_next.w_held
                                 && !state_next.rsp.bvalid;

        // Read answers the cycle after the address is taken
        if (ar_take) begin
            state_next.rsp.rvalid = 1'b1;
            if (reg_mapped(axi_req.araddr)) begin
                state_next.rsp.rdata =
                    {24'h000000, reg_read(reg_index(axi_req.araddr),
                                          state_reg)};
                state_next.rsp.rresp = wse_pkg::RESP_OKAY;
            end else begin
                state_next.rsp.rdata = 32'h00000000;
                state_next.rsp.rresp = wse_pkg::RESP_DECERR;
            end
        end else if (state_reg.rsp.rvalid && axi_req.rready) begin
            state_next.rsp.rvalid = 1'b0;
        end
        state_next.rsp.arready = !state_next.rsp.rvalid;

        // Standby reset clears bus and status except the alarm flag; battery reset clears all
        if (!aresetn || !battery_reset_n) begin
            state_next.sync_a            = wse_pkg::SYNC_RST;
            state_next.sync_b            = wse_pkg::SYNC_RST;
            state_next.prev              = wse_pkg::SYNC_RST;
            state_next.ge_sts            = wse_pkg::GE_STS_RST;
            state_next.button_event_flag = 1'b0;
            state_next.pm_event_n        = 1'b1;
            state_next.supply_n          = 1'b1;
            state_next.aw_held           = 1'b0;
            state_next.awaddr            = '0;
            state_next.w_held            = 1'b0;
            state_next.wdata             = 8'h00;
            state_next.wlane             = 1'b0;
            state_next.rsp               = '0;
        end
        // Enables survive standby loss; only the battery reset clears them
        if (!battery_reset_n) begin
            state_next.pm_en      = wse_pkg::PM_EN_RST;
            state_next.ge_en      = wse_pkg::GE_EN_RST;
            state_next.pol        = wse_pkg::POL_RST;
            state_next.alarm_flag = 1'b0;
        end
    end

    // Single state register
    always_ff @(posedge aclk) begin
        state_reg <= state_next;
    end

    // Outputs straight from flip-flops
    assign axi_rsp        = state_reg.rsp;
    assign pm_event_out_n = state_reg.pm_event_n;
    assign supply_on_n    = state_reg.supply_n;

endmodule : wse_wake_event

// >>> common/wse_pkg.sv
// Constants, register map and carrier types for the wake event block
package wse_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PM_EN_LOW   = 8'h7a;
    localparam logic [7:0] IDX_PM_EN_HIGH  = 8'h7b;
    localparam logic [7:0] IDX_GE_STS_LOW  = 8'h7c;
    localparam logic [7:0] IDX_GE_STS_HIGH = 8'h7d;
    localparam logic [7:0] IDX_GE_EN_LOW   = 8'h7e;
    localparam logic [7:0] IDX_GE_EN_HIGH  = 8'h7f;
    localparam logic [7:0] IDX_PM_STATUS   = 8'h80;
    localparam logic [7:0] IDX_POL_LOW     = 8'h81;
    localparam logic [7:0] IDX_POL_HIGH    = 8'h82;
    localparam logic [7:0] IDX_SUPPLY_CTRL = 8'h83;

    // Field positions
    localparam int BIT_BUTTON   = 0;
    localparam int BIT_ALARM    = 2;
    localparam int BIT_SLEEP    = 0;
    localparam int SRC_BUTTON   = 16;
    localparam int SRC_ALARM    = 17;

    // Writable bits of the second power enable register
    localparam logic [7:0]  PM_EN_MASK   = 8'h05;
    // Sources judged on the falling edge when not inverted
    localparam logic [15:0] FALL_MASK    = 16'h0058;

    // Reset values
    localparam logic [7:0]  PM_EN_RST    = 8'h00;
    localparam logic [15:0] GE_STS_RST   = 16'h0000;
    localparam logic [15:0] GE_EN_RST    = 16'h0000;
    localparam logic [15:0] POL_RST      = 16'h0000;
    localparam logic [17:0] SYNC_RST     = 18'h10000;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;
    localparam int          ADDR_W       = 12;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic [2:0]        awprot;
        logic              awvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              wvalid;
        logic              bready;
        logic [ADDR_W-1:0] araddr;
        logic [2:0]        arprot;
        logic              arvalid;
        logic              rready;
    } wse_axi_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic [1:0]        bresp;
        logic              bvalid;
        logic              arready;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              rvalid;
    } wse_axi_rsp_t;

    typedef struct packed {
        logic [17:0]       sync_a;
        logic [17:0]       sync_b;
        logic [17:0]       prev;
        logic [7:0]        pm_en;
        logic [15:0]       ge_sts;
        logic [15:0]       ge_en;
        logic [15:0]       pol;
        logic              button_event_flag;
        logic              alarm_flag;
        logic              pm_event_n;
        logic              supply_n;
        logic              aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;
        logic [7:0]        wdata;
        logic              wlane;
        wse_axi_rsp_t      rsp;
    } wse_state_t;

endpackage : wse_pkg

// >>> testbench/wse_monitor.sv
// Port-level assertions for the wake event block
`timescale 1ns/1ns
module wse_monitor (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  battery_reset_n,
    input wire logic                  button_input_n,
    input wire wse_pkg::wse_axi_req_t axi_req,
    input wire wse_pkg::wse_axi_rsp_t axi_rsp,
    input wire logic                  pm_event_out_n,
    input wire logic                  supply_on_n
);
    // Either reset stops all checks except the two reset checks below
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !battery_reset_n);

    a_reserved_zero: assert property (
        axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 12'h1e8
        |=> axi_rsp.rvalid && axi_rsp.rdata == 32'h0)
        else $error("reserved register read not zero");
    a_button_wake: assert property (
        $fell(button_input_n) |-> ##[1:8] !supply_on_n)
        else $error("button press did not wake");
    // Reset checks must run while reset is held
    a_reset_idle: assert property (disable iff (1'b0)
        !aresetn |=> pm_event_out_n && supply_on_n && !axi_rsp.bvalid)
        else $error("standby reset left outputs active");
    a_battery_idle: assert property (disable iff (1'b0)
        !battery_reset_n |=> pm_event_out_n && supply_on_n && !axi_rsp.rvalid)
        else $error("battery reset left outputs active");
    // Held address and data meet one cycle later, response one after that
    a_write_answer: assert property (
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##2 axi_rsp.bvalid)
        else $error("write response late");
    a_aw_refused: assert property (
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write accepted during response");
    a_bresp_release: assert property (
        axi_rsp.bvalid && axi_req.bready
        |=> !axi_rsp.bvalid ##[0:1] axi_rsp.awready)
        else $error("write response not retired");
    a_read_release: assert property (
        axi_rsp.rvalid && axi_req.rready
        |=> !axi_rsp.rvalid ##[0:1] axi_rsp.arready)
        else $error("read response not retired");
endmodule : wse_monitor

bind wse_wake_event wse_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .battery_reset_n(battery_reset_n), .button_input_n(button_input_n),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pm_event_out_n(pm_event_out_n),
    .supply_on_n(supply_on_n));

// >>> testbench/wse_wake_event_tb.sv
// Self-checking bench for the wake event block
`timescale 1ns/1ns
module wse_wake_event_tb;
    logic                  aclk;
    logic                  aresetn;
    logic                  battery_reset_n;
    logic                  button_input_n;
    logic                  alarm_in;
    logic [7:0]            gp_low_in;
    logic [7:0]            pin_bank_in;
    wse_pkg::wse_axi_req_t axi_req;
    wse_pkg::wse_axi_rsp_t axi_rsp;
    logic                  pm_event_out_n;
    logic                  supply_on_n;
    int                    miscompares = 0;
    int                    n_compared = 0;
    int                    cycles = 0;
    logic [1:0]            rs;

    wse_wake_event dut (.aclk(aclk), .aresetn(aresetn),
        .battery_reset_n(battery_reset_n), .button_input_n(button_input_n),
        .alarm_in(alarm_in), .gp_low_in(gp_low_in), .pin_bank_in(pin_bank_in),
        .axi_req(axi_req), .axi_rsp(axi_rsp),
        .pm_event_out_n(pm_event_out_n), .supply_on_n(supply_on_n));

    // 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Each channel released at its own handshake; bready stays high
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        axi_req.awaddr <= {2'b00, idx, 2'b00};
        axi_req.wdata <= {24'h000000, d};
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && axi_rsp.awready === 1'b1) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_done && axi_rsp.wready === 1'b1) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (axi_rsp.bvalid !== 1'b1);
        rs = axi_rsp.bresp;
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        axi_req.araddr <= {2'b00, idx, 2'b00};
        axi_req.arvalid <= 1'b1;
        do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        do @(posedge aclk); while (axi_rsp.rvalid !== 1'b1);
        rs = axi_rsp.rresp;
        check(axi_rsp.rdata, {24'h000000, exp});
    endtask : rdchk

    // Toggle one event source, then let it cross the synchroniser
    task automatic flip(input int i);
        if (i < 8)
            gp_low_in[i] <= ~gp_low_in[i];
        else
            pin_bank_in[i-8] <= ~pin_bank_in[i-8];
        cyc(6);
    endtask : flip

    task automatic t_regs();
        for (int i = 8'h7a; i <= 8'h7f; i++)
            rdchk(8'(i), 8'h00);
        wr(8'h7a, 8'hff);
        rdchk(8'h7a, 8'h00);
        wr(8'h7b, 8'hff);
        rdchk(8'h7b, 8'h05);
        wr(8'h7b, 8'h00);
        check(32'(rs), 32'h0);
        // Unmapped word: write refused, read returns zero
        wr(8'h99, 8'hff);
        check(32'(rs), 32'h3);
        rdchk(8'h99, 8'h00);
        check(32'(rs), 32'h3);
        $display("test regs done");
    endtask : t_regs

    task automatic t_events();
        logic [15:0] e;
        for (int i = 0; i < 16; i++) begin
            e = 16'h0001 << i;
            flip(i);
            flip(i);
            wr(8'h7c, 8'h00);
            wr(8'h7d, 8'h00);
            rdchk(8'h7c, e[7:0]);
            rdchk(8'h7d, e[15:8]);
            wr(8'h7c, e[7:0]);
            wr(8'h7d, e[15:8]);
        end
        rdchk(8'h7c, 8'h00);
        // Inverted pin a: rising edge ignored, falling edge counts
        wr(8'h81, 8'h01);
        flip(0);
        rdchk(8'h7c, 8'h00);
        flip(0);
        rdchk(8'h7c, 8'h01);
        wr(8'h81, 8'h00);
        wr(8'h7e, 8'h01);
        // Outputs follow the enable one edge later; let them settle
        cyc(2);
        check(32'({pm_event_out_n, supply_on_n}), 32'h0);
        wr(8'h7c, 8'h01);
        wr(8'h7e, 8'h00);
        wr(8'h83, 8'h01);
        cyc(2);
        check(32'({pm_event_out_n, supply_on_n}), 32'h3);
        $display("test events done");
    endtask : t_events

    task automatic t_button();
        button_input_n <= 1'b0;
        cyc(8);
        check(32'({pm_event_out_n, supply_on_n}), 32'h2);
        rdchk(8'h80, 8'h01);
        wr(8'h7b, 8'h01);
        cyc(2);
        check(32'(pm_event_out_n), 32'h0);
        button_input_n <= 1'b1;
        cyc(6);
        wr(8'h80, 8'h01);
        wr(8'h7b, 8'h00);
        wr(8'h83, 8'h01);
        cyc(2);
        check(32'({pm_event_out_n, supply_on_n}), 32'h3);
        $display("test button done");
    endtask : t_button

    task automatic t_alarm();
        alarm_in <= 1'b1;
        cyc(6);
        alarm_in <= 1'b0;
        wr(8'h80, 8'h00);
        rdchk(8'h80, 8'h04);
        check(32'({pm_event_out_n, supply_on_n}), 32'h3);
        // Enables must outlive a standby reset
        wr(8'h7f, 8'h81);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(2);
        rdchk(8'h80, 8'h04);
        rdchk(8'h7f, 8'h81);
        wr(8'h7b, 8'h04);
        cyc(2);
        check(32'({pm_event_out_n, supply_on_n}), 32'h0);
        battery_reset_n <= 1'b0;
        cyc(2);
        battery_reset_n <= 1'b1;
        cyc(2);
        rdchk(8'h7b, 8'h00);
        rdchk(8'h7f, 8'h00);
        rdchk(8'h80, 8'h00);
        // Fresh alarm, then software clears it by writing one
        alarm_in <= 1'b1;
        cyc(6);
        alarm_in <= 1'b0;
        rdchk(8'h80, 8'h04);
        wr(8'h80, 8'h04);
        rdchk(8'h80, 8'h00);
        $display("test alarm done");
    endtask : t_alarm

    // Falling-edge sources idle high; bready and rready stay high
    initial begin
        aresetn = 1'b0;
        battery_reset_n = 1'b0;
        button_input_n = 1'b1;
        alarm_in = 1'b0;
        gp_low_in = 8'h58;
        pin_bank_in = 8'h00;
        axi_req = '0;
        axi_req.wstrb = 4'hf;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        cyc(5);
        aresetn <= 1'b1;
        battery_reset_n <= 1'b1;
        cyc(2);
        t_regs();
        t_events();
        t_button();
        t_alarm();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
endmodule : wse_wake_event_tb
